// File: logic/thlmc_pkg.sv
// Purpose: shared constants and types for the timer hardware limit mode control
// Assumes: one clock; the timer clock is mclk itself
// Notes: mode codes are the full five-bit field, family in [4:3], variant in [2:0]
package thlmc_pkg;
  localparam int MODE_W = 5;
  localparam int CNT_W = 8;
  localparam logic [1:0] FAM_FREE = 2'h0;
  localparam logic [1:0] FAM_ONESHOT = 2'h1;
  localparam logic [1:0] FAM_MONO = 2'h2;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic ON_RST = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [4:0] {
    MODE_SW_GATE = 5'h00,
    MODE_GATE_HI = 5'h01,
    MODE_GATE_LO = 5'h02,
    MODE_RST_ANY = 5'h03,
    MODE_RST_RISE = 5'h04,
    MODE_RST_FALL = 5'h05,
    MODE_RST_LOW = 5'h06,
    MODE_RST_HIGH = 5'h07,
    OS_SOFT = 5'h08,
    OS_RISE = 5'h09,
    OS_FALL = 5'h0a,
    OS_ANY = 5'h0b,
    OS_RISE_RRST = 5'h0c,
    OS_FALL_FRST = 5'h0d,
    OS_RISE_LRST = 5'h0e,
    OS_FALL_HRST = 5'h0f,
    MS_RISE = 5'h11,
    MS_FALL = 5'h12,
    MS_ANY = 5'h13,
    MS_HIGH_LRST = 5'h16,
    MS_LOW_HRST = 5'h17
  } thlmc_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } thlmc_state_t;

  typedef struct packed {
    logic on_set;
    logic on_clr;
    logic debug_mode;
  } thlmc_ctrl_t;

  typedef struct packed {
    logic timer_on;
    logic running;
    logic period_match;
  } thlmc_stat_t;
endpackage

// File: logic/thlmc_timer.sv
// Purpose: mode selection and start, stop and reset control of an 8-bit period timer
// Assumes: software drives the enable bit through set and clear pulses; period is static while counting
// Notes: external signal is synchronised by three flops and filtered on agreement of the last two
//
// Overview of operation
// - five-bit mode, family bits 4:3, variant 2:0
// - external input ignored during debug
// - code 00011 resets count on any edge
// - codes 00100/00101 reset on rising/falling edge
// - one-shot starts on enable plus chosen edge, code 01000 on enable alone
// - code 01100 starts and resets on rise
// - codes 01101..01111 edge start with edge/level reset
// - re-enable in edge-start modes needs a new qualifying edge
// - one-shot match clears enable, count to zero
// - monostable match stops at zero, enable kept
// - software gate counts only while enabled
// - codes 00110/00111 held reset at low/high
// - increment, flag match, clear on next clock
`timescale 1ns/1ps
module thlmc_timer #(
  parameter int CNT_W = thlmc_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire thlmc_pkg::thlmc_ctrl_t ctrl,
  input wire logic [thlmc_pkg::MODE_W-1:0] timer_limit_control_reg,
  input wire logic [CNT_W-1:0] timer_period_value,
  input wire logic timer_external_reset_signal,
  output logic [CNT_W-1:0] timer_count_value,
  output thlmc_pkg::thlmc_stat_t stat
);

  ////////////////////////////////////////////////////////////////////////////
  // external signal synchroniser and filter

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    sync_nxt = {sync_r[1:0], timer_external_reset_signal};
    lvl_nxt = lvl_r;
    // frozen in debug so no edge or level can act
    if (!ctrl.debug_mode && (sync_r[1] == sync_r[2])) begin
      lvl_nxt = sync_r[2];
    end
    prev_nxt = lvl_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= thlmc_pkg::SYNC_RST;
      lvl_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      lvl_r <= lvl_nxt;
      prev_r <= prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  logic [1:0] fam;
  logic rise;
  logic fall;
  logic hi;
  logic lo;
  logic start_ev;
  logic rst_ev;
  logic gate_ok;
  logic reserved;

  always_comb begin
    fam = timer_limit_control_reg[4:3];
    rise = lvl_r & ~prev_r & ~ctrl.debug_mode;
    fall = ~lvl_r & prev_r & ~ctrl.debug_mode;
    hi = lvl_r & ~ctrl.debug_mode;
    lo = ~lvl_r & ~ctrl.debug_mode;
    start_ev = 1'b0;
    rst_ev = 1'b0;
    gate_ok = 1'b1;
    reserved = 1'b0;
    case (timer_limit_control_reg)
      thlmc_pkg::MODE_SW_GATE: begin
        gate_ok = 1'b1;
      end
      thlmc_pkg::MODE_GATE_HI: begin
        gate_ok = hi | ctrl.debug_mode;
      end
      thlmc_pkg::MODE_GATE_LO: begin
        gate_ok = lo | ctrl.debug_mode;
      end
      thlmc_pkg::MODE_RST_ANY: begin
        rst_ev = rise | fall;
      end
      thlmc_pkg::MODE_RST_RISE: begin
        rst_ev = rise;
      end
      thlmc_pkg::MODE_RST_FALL: begin
        rst_ev = fall;
      end
      thlmc_pkg::MODE_RST_LOW: begin
        rst_ev = lo;
      end
      thlmc_pkg::MODE_RST_HIGH: begin
        rst_ev = hi;
      end
      thlmc_pkg::OS_SOFT: begin
        start_ev = 1'b1;
      end
      thlmc_pkg::OS_RISE, thlmc_pkg::MS_RISE: begin
        start_ev = rise;
      end
      thlmc_pkg::OS_FALL, thlmc_pkg::MS_FALL: begin
        start_ev = fall;
      end
      thlmc_pkg::OS_ANY, thlmc_pkg::MS_ANY: begin
        start_ev = rise | fall;
      end
      thlmc_pkg::OS_RISE_RRST: begin
        start_ev = rise;
        rst_ev = rise;
      end
      thlmc_pkg::OS_FALL_FRST: begin
        start_ev = fall;
        rst_ev = fall;
      end
      thlmc_pkg::OS_RISE_LRST: begin
        start_ev = rise;
        rst_ev = lo;
      end
      thlmc_pkg::OS_FALL_HRST: begin
        start_ev = fall;
        rst_ev = hi;
      end
      thlmc_pkg::MS_HIGH_LRST: begin
        start_ev = hi;
        rst_ev = lo;
      end
      thlmc_pkg::MS_LOW_HRST: begin
        start_ev = lo;
        rst_ev = hi;
      end
      default: begin
        reserved = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable, run state and counter

  logic on_r;
  logic on_nxt;
  thlmc_pkg::thlmc_state_t st_r;
  thlmc_pkg::thlmc_state_t st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic counting;
  logic hit;

  always_comb begin
    on_nxt = on_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    hit = (cnt_r == timer_period_value);
    if (fam == thlmc_pkg::FAM_FREE) begin
      counting = on_r & gate_ok;
    end else begin
      counting = on_r & (st_r == thlmc_pkg::ST_RUN);
    end
    if (ctrl.on_clr) begin
      on_nxt = 1'b0;
    end
    if (ctrl.on_set) begin
      on_nxt = 1'b1;
    end
    if (reserved) begin
      cnt_nxt = thlmc_pkg::CNT_RST;
      st_nxt = thlmc_pkg::ST_IDLE;
    end else if (!on_r) begin
      st_nxt = thlmc_pkg::ST_IDLE;
    end else begin
      if ((fam != thlmc_pkg::FAM_FREE) && (st_r == thlmc_pkg::ST_IDLE) && start_ev) begin
        st_nxt = thlmc_pkg::ST_RUN;
      end
      if (rst_ev) begin
        cnt_nxt = thlmc_pkg::CNT_RST;
      end else if (counting) begin
        if (hit) begin
          cnt_nxt = thlmc_pkg::CNT_RST;
          if (fam == thlmc_pkg::FAM_ONESHOT) begin
            // a software set in the same cycle wins over the hardware clear
            on_nxt = ctrl.on_set;
            st_nxt = thlmc_pkg::ST_IDLE;
          end else if (fam == thlmc_pkg::FAM_MONO) begin
            st_nxt = thlmc_pkg::ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_r <= thlmc_pkg::ON_RST;
      st_r <= thlmc_pkg::ST_IDLE;
      cnt_r <= thlmc_pkg::CNT_RST;
    end else begin
      on_r <= on_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign timer_count_value = cnt_r;
  assign stat.timer_on = on_r;
  assign stat.running = counting;
  assign stat.period_match = on_r & counting & hit & ~rst_ev & ~reserved;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic [4:0] m;
  assign m = timer_limit_control_reg;

  reserved_stop_a: assert property (
    reserved |=> cnt_r == 8'h00 && st_r == thlmc_pkg::ST_IDLE)
    else $error("reserved mode left counter running");
  oneshot_end_a: assert property (
    fam == thlmc_pkg::FAM_ONESHOT && counting && hit && !rst_ev && !reserved && !ctrl.on_set
    |=> !on_r && cnt_r == 8'h00 ##1 cnt_r == 8'h00)
    else $error("one-shot did not stop with enable cleared");
  mono_end_a: assert property (
    fam == thlmc_pkg::FAM_MONO && counting && hit && !rst_ev && !reserved && !ctrl.on_clr
    |=> on_r && cnt_r == 8'h00 && st_r == thlmc_pkg::ST_IDLE)
    else $error("monostable stop wrong");
  swgate_count_a: assert property (
    m == 5'h00 && on_r && !hit |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("software gate did not count");
  swgate_hold_a: assert property (
    m == 5'h00 && !on_r |=> $stable(cnt_r))
    else $error("count moved while disabled");
  debug_freeze_a: assert property (
    ctrl.debug_mode |=> $stable(lvl_r) && !rise && !fall)
    else $error("external input acted in debug");
  edge_reset_a: assert property (
    m == 5'h03 && on_r && (rise || fall) |=> cnt_r == 8'h00)
    else $error("any-edge reset missed");
  rise_reset_a: assert property (
    m == 5'h04 && on_r && rise |=> cnt_r == 8'h00)
    else $error("rising-edge reset missed");
  level_reset_a: assert property (
    m == 5'h06 && on_r && lo [*2] |-> cnt_r == 8'h00)
    else $error("low-level reset not held");
  gate_pause_a: assert property (
    m == 5'h01 && lo |=> $stable(cnt_r))
    else $error("hardware gate failed to pause");
  edge_rearm_a: assert property (
    m == 5'h09 && on_r && st_r == thlmc_pkg::ST_IDLE && !rise |=> st_r == thlmc_pkg::ST_IDLE)
    else $error("restart without a new edge");
  os_start_a: assert property (
    m == 5'h09 && on_r && st_r == thlmc_pkg::ST_IDLE && rise |=> st_r == thlmc_pkg::ST_RUN)
    else $error("rising-edge start missed");
  os_rerise_a: assert property (
    m == 5'h0c && on_r && st_r == thlmc_pkg::ST_RUN && rise |=> cnt_r == 8'h00)
    else $error("later rising edge did not reset");
  match_clear_a: assert property (
    stat.period_match |=> cnt_r == 8'h00)
    else $error("count not cleared after match");
  os_level_reset_a: assert property (
    m == 5'h0e && on_r && lo |=> cnt_r == 8'h00)
    else $error("low-level reset missed in one-shot");
  mono_level_start_a: assert property (
    m == 5'h16 && on_r && st_r == thlmc_pkg::ST_IDLE && hi |=> st_r == thlmc_pkg::ST_RUN)
    else $error("high-level start missed");
  gate_lo_pause_a: assert property (
    m == 5'h02 && hi |=> $stable(cnt_r))
    else $error("active-low gate failed to pause");

  oneshot_done_c: cover property (fam == thlmc_pkg::FAM_ONESHOT && stat.period_match);
  mono_restart_c: cover property (
    fam == thlmc_pkg::FAM_MONO && stat.period_match ##[1:40] st_r == thlmc_pkg::ST_RUN);
  free_reset_c: cover property (fam == thlmc_pkg::FAM_FREE && on_r && rst_ev && cnt_r != 8'h00);
  gate_pause_c: cover property (m == 5'h02 && on_r && !gate_ok);
  soft_start_c: cover property (m == 5'h08 && on_r && st_r == thlmc_pkg::ST_RUN);

endmodule

// File: tb/tb_top.sv
// Purpose: self-checking bench of the timer mode control
// Assumes: timer clock is mclk; external pin comes from thlmc_src
// Notes: each scenario starts from a count forced to zero by a reserved code
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  thlmc_pkg::thlmc_ctrl_t ctrl = '0;
  logic [4:0] mode = 5'h00;
  logic [7:0] per = 8'h03;
  logic want = 1'b0;
  logic ers;
  logic [7:0] cnt;
  thlmc_pkg::thlmc_stat_t stat;
  int fails = 0;
  int tests_run = 0;
  always #12.5 mclk = ~mclk;
  thlmc_src src (.mclk(mclk), .rst_n(rst_n), .want(want), .ers(ers));
  thlmc_timer DUT (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .timer_limit_control_reg(mode),
    .timer_period_value(per), .timer_external_reset_signal(ers), .timer_count_value(cnt), .stat(stat));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input logic [4:0] m, input logic [7:0] p);
    @(posedge mclk);
    ctrl.on_clr <= 1'b1;
    mode <= 5'h10;
    per <= p;
    @(posedge mclk);
    ctrl.on_clr <= 1'b0;
    @(posedge mclk);
    mode <= m;
    ctrl.on_set <= 1'b1;
    @(posedge mclk);
    ctrl.on_set <= 1'b0;
    #1;
  endtask
  task automatic set_lvl(input logic v);
    int n = 0;
    @(posedge mclk);
    want <= v;
    while (ers !== v && n < 20) begin
      @(posedge mclk);
      n++;
    end
    #1;
    if (ers !== v) begin
      fails++;
      close_out();
    end
  endtask
  task automatic wait_match();
    int n = 0;
    while (stat.period_match !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    if (stat.period_match !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sw_gate();
    start(5'h00, 8'h03);
    wait_match();
    chk("count at match", 8'h03, cnt);
    cyc(1);
    chk("count after match", 8'h00, cnt);
    @(posedge mclk);
    ctrl.on_clr <= 1'b1;
    @(posedge mclk);
    ctrl.on_clr <= 1'b0;
    cyc(5);
    chk("count held", 8'h02, cnt);
  endtask
  task automatic mid_reset();
    start(5'h00, 8'hff);
    cyc(5);
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(2);
    chk("reset count", 8'h00, cnt);
    chk("reset status", 8'h00, {5'h00, stat});
    @(posedge mclk);
    rst_n <= 1'b1;
    cyc(3);
    chk("idle after reset", 8'h00, {cnt[6:0], stat.timer_on});
  endtask
  task automatic hw_gate();
    set_lvl(1'b0);
    start(5'h01, 8'hff);
    cyc(8);
    chk("gate closed", 8'h00, cnt);
    set_lvl(1'b1);
    cyc(10);
    chk("gate open", 8'h01, {7'h00, cnt != 8'h00});
    chk("gate running", 8'h01, {7'h00, stat.running});
    start(5'h02, 8'hff);
    cyc(8);
    chk("low gate closed", 8'h00, cnt);
    chk("low gate idle", 8'h00, {7'h00, stat.running});
    set_lvl(1'b0);
    cyc(10);
    chk("low gate open", 8'h01, {7'h00, cnt != 8'h00});
  endtask
  task automatic edge_resets();
    logic [2:0] rise_tab = 3'b011;
    logic [2:0] fall_tab = 3'b101;
    for (int i = 0; i < 3; i++) begin
      start(5'(3 + i), 8'hff);
      repeat (2) begin
        cyc(30);
        set_lvl(~want);
        cyc(8);
        chk("edge reset", {7'h00, want ? rise_tab[i] : fall_tab[i]}, {7'h00, cnt < 8'h0c});
      end
    end
  endtask
  task automatic levels();
    set_lvl(1'b0);
    start(5'h06, 8'hff);
    cyc(10);
    chk("low level reset", 8'h00, cnt);
    set_lvl(1'b1);
    cyc(10);
    chk("low level release", 8'h01, {7'h00, cnt != 8'h00});
    start(5'h07, 8'hff);
    cyc(10);
    chk("high level reset", 8'h00, cnt);
  endtask
  task automatic one_shot();
    set_lvl(1'b1);
    start(5'h09, 8'h02);
    cyc(10);
    chk("no edge no start", 8'h00, cnt);
    set_lvl(1'b0);
    cyc(10);
    chk("wrong edge", 8'h00, cnt);
    set_lvl(1'b1);
    wait_match();
    chk("one shot match", 8'h02, cnt);
    cyc(1);
    chk("one shot end", 8'h00, {cnt[6:0], stat.timer_on});
    for (int v = 0; v < 2; v++) begin
      set_lvl(v[0]);
      start({4'h6, v[0]}, 8'hff);
      set_lvl(~v[0]);
      cyc(30);
      set_lvl(v[0]);
      cyc(8);
      chk("opposite edge no reset", 8'h00, {7'h00, cnt < 8'h0c});
      set_lvl(~v[0]);
      cyc(8);
      chk("same edge reset", 8'h01, {7'h00, cnt < 8'h0c});
    end
  endtask
  task automatic mono();
    set_lvl(1'b0);
    start(5'h11, 8'h02);
    set_lvl(1'b1);
    wait_match();
    cyc(1);
    chk("mono end", 8'h01, {cnt[6:0], stat.timer_on});
    set_lvl(1'b0);
    set_lvl(1'b1);
    wait_match();
    chk("mono restart", 8'h02, cnt);
  endtask
  task automatic os_soft();
    start(5'h08, 8'h02);
    wait_match();
    chk("soft start match", 8'h02, cnt);
    cyc(3);
    chk("soft start end", 8'h00, {cnt[6:0], stat.timer_on});
  endtask
  task automatic edge_starts();
    logic [4:0] codes [4] = '{5'h0a, 5'h0b, 5'h12, 5'h13};
    foreach (codes[i]) begin
      set_lvl(1'b0);
      start(codes[i], 8'h20);
      set_lvl(1'b1);
      cyc(8);
      chk("rise start", {7'h00, codes[i][0]}, {7'h00, cnt != 8'h00});
      set_lvl(1'b0);
      wait_match();
      chk("edge start match", 8'h20, cnt);
      cyc(1);
      chk("edge start end", {7'h00, codes[i][4]}, {cnt[6:0], stat.timer_on});
    end
  endtask
  task automatic level_starts();
    logic [4:0] codes [4] = '{5'h0e, 5'h0f, 5'h16, 5'h17};
    foreach (codes[i]) begin
      set_lvl(codes[i][0]);
      start(codes[i], 8'hff);
      cyc(8);
      chk("level idle", 8'h00, cnt);
      set_lvl(~codes[i][0]);
      cyc(10);
      chk("level start", 8'h01, {7'h00, cnt != 8'h00});
      set_lvl(codes[i][0]);
      cyc(8);
      chk("level reset", 8'h00, cnt);
    end
  endtask
  task automatic reserved();
    logic [4:0] codes [5] = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1f};
    foreach (codes[i]) begin
      start(codes[i], 8'h02);
      set_lvl(~want);
      cyc(10);
      chk("reserved count", 8'h00, cnt);
    end
  endtask
  task automatic debug();
    start(5'h04, 8'hff);
    @(posedge mclk);
    ctrl.debug_mode <= 1'b1;
    cyc(30);
    set_lvl(~want);
    set_lvl(~want);
    cyc(8);
    chk("debug ignores", 8'h00, {7'h00, cnt < 8'h0c});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    sw_gate();
    mid_reset();
    hw_gate();
    edge_resets();
    levels();
    one_shot();
    mono();
    os_soft();
    edge_starts();
    level_starts();
    reserved();
    debug();
    close_out();
  end
endmodule

// File: tb/thlmc_src.sv
// Purpose: far-side model of the external reset and trigger source
// Assumes: the bench asks for a level on want; the pin follows when spacing allows
// Notes: the pin never changes twice within six clocks
`timescale 1ns/1ps
module thlmc_src (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic want,
  output logic ers
);
  logic [3:0] gap_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ers <= 1'b0;
      gap_r <= 4'h0;
    end else if (want != ers && gap_r >= 4'h6) begin
      ers <= want;
      gap_r <= 4'h0;
    end else if (gap_r != 4'hf) begin
      gap_r <= gap_r + 4'h1;
    end
  end
endmodule
